// *** hdl/hss_sequencer.v ***
// home search sequencer: axi4-lite registers, search state machine, feedback referencing
// assumes encoder counts arrive as same-clock step pulses; switch and marker are raw pins
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "hss_regs.vh"
module hss_sequencer #(
   parameter POS_W = 32
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire home_switch_pin,
   input wire encoder_marker_pulse,
   input wire motor_step,
   input wire motor_step_up,
   input wire direct_step,
   input wire direct_step_up,
   output reg [31:0] speed_cmd_reg,
   output reg motor_dir_neg_reg,
   output reg motor_run_reg
);
   localparam ST_IDLE = 3'd0;
   localparam ST_FAST = 3'd1;
   localparam ST_LEAVE = 3'd2;
   localparam ST_SLOW = 3'd3;
   localparam ST_CALC = 3'd4;
   localparam ST_SETFB = 3'd5;
   localparam ST_DONE = 3'd6;

   reg [2:0] state_reg;
   reg [31:0] cfg_reg, fast_reg, slow_reg, sw_plc_reg;
   reg [POS_W-1:0] mref_dist_reg, mref_ofs_reg, dref_dist_reg, dref_ofs_reg;
   reg [POS_W-1:0] shift_reg, mfb_reg, dfb_reg, mark_reg, mdisp_reg, ddisp_reg;
   reg [POS_W-1:0] cmd_pos_reg, edge_pos_reg, dist_reg;
   reg marker_flag_reg, referenced_reg, abs_ok_reg;
   reg sw_s1_reg, sw_s2_reg, mk_s1_reg, mk_s2_reg, mk_d_reg;
   reg [1:0] wr_got_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   wire sw_raw, sw_active, marker_rise, use_direct;
   wire [POS_W-1:0] fb_sel, sw_eff_edge;

   // signed step: +1, -1 or hold
   function [POS_W-1:0] hss_step;
      input [POS_W-1:0] v;
      input s;
      input up;
      begin
         hss_step = s ? (up ? v + 1'b1 : v - 1'b1) : v;
      end
   endfunction

   // pin inputs pass two flops before use
   always @(posedge aclk) begin
      sw_s1_reg <= home_switch_pin;
      sw_s2_reg <= sw_s1_reg;
      mk_s1_reg <= encoder_marker_pulse;
      mk_s2_reg <= mk_s1_reg;
      mk_d_reg <= mk_s2_reg;
   end

   assign marker_rise = mk_s2_reg & ~mk_d_reg;
   // plc or cnc writes the status word; else the digital input drives it
   assign sw_raw = cfg_reg[`HSS_CFG_PLC] ? sw_plc_reg[0] : sw_s2_reg;
   assign sw_active = sw_raw ^ cfg_reg[`HSS_CFG_POL];
   assign use_direct = cfg_reg[`HSS_CFG_DIRECT];
   assign fb_sel = use_direct ? dfb_reg : mfb_reg;
   // software shift of the switch edge by the calibration offset
   assign sw_eff_edge = edge_pos_reg + shift_reg;

   // axi write: address and data in either order, response after both
   wire wr_fire = (wr_got_reg == 2'b11) & ~s_axi_bvalid;
   assign s_axi_awready = ~wr_got_reg[0] & ~s_axi_bvalid;
   assign s_axi_wready = ~wr_got_reg[1] & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire wr_ctrl = wr_fire & (awaddr_reg == `HSS_CTRL_OFF);
   wire home_cmd = wr_ctrl & wdata_reg[`HSS_CTRL_HOME];
   wire cal_cmd = wr_ctrl & wdata_reg[`HSS_CTRL_CAL];

   function hss_mapped;
      input [7:0] a;
      begin
         hss_mapped = (a[1:0] == 2'b00) && (a <= `HSS_SWSTAT_OFF);
      end
   endfunction

   function [31:0] hss_merge;
      input [31:0] old;
      input [31:0] d;
      input [3:0] s;
      integer i;
      begin
         hss_merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (s[i]) hss_merge[i*8 +: 8] = d[i*8 +: 8];
         end
      end
   endfunction

   reg [3:0] wstrb_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_got_reg <= 2'b00;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `HSS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
            wr_got_reg[0] <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            wr_got_reg[1] <= 1'b1;
         end
         if (wr_fire) begin
            wr_got_reg <= 2'b00;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hss_mapped(awaddr_reg) ? `HSS_RESP_OKAY : `HSS_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers written by software
   always @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= 32'h00000000;
         fast_reg <= `HSS_FAST_RST;
         slow_reg <= `HSS_SLOW_RST;
         sw_plc_reg <= 32'h00000000;
         mref_dist_reg <= {POS_W{1'b0}};
         mref_ofs_reg <= {POS_W{1'b0}};
         dref_dist_reg <= {POS_W{1'b0}};
         dref_ofs_reg <= {POS_W{1'b0}};
      end else if (wr_fire) begin
         case (awaddr_reg)
            `HSS_CFG_OFF: cfg_reg <= hss_merge(cfg_reg, wdata_reg, wstrb_reg);
            `HSS_FAST_OFF: fast_reg <= hss_merge(fast_reg, wdata_reg, wstrb_reg);
            `HSS_SLOW_OFF: slow_reg <= hss_merge(slow_reg, wdata_reg, wstrb_reg);
            `HSS_SWSTAT_OFF: sw_plc_reg <= hss_merge(sw_plc_reg, wdata_reg, wstrb_reg);
            `HSS_MREFDIST_OFF: mref_dist_reg <= hss_merge(mref_dist_reg, wdata_reg, wstrb_reg);
            `HSS_MREFOFS_OFF: mref_ofs_reg <= hss_merge(mref_ofs_reg, wdata_reg, wstrb_reg);
            `HSS_DREFDIST_OFF: dref_dist_reg <= hss_merge(dref_dist_reg, wdata_reg, wstrb_reg);
            `HSS_DREFOFS_OFF: dref_ofs_reg <= hss_merge(dref_ofs_reg, wdata_reg, wstrb_reg);
            default: cfg_reg <= cfg_reg;
         endcase
      end
   end

   // search sequencer and position bookkeeping
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         // power-up point is the feedback origin
         mfb_reg <= {POS_W{1'b0}};
         dfb_reg <= {POS_W{1'b0}};
         mark_reg <= {POS_W{1'b0}};
         mdisp_reg <= {POS_W{1'b0}};
         ddisp_reg <= {POS_W{1'b0}};
         cmd_pos_reg <= {POS_W{1'b0}};
         edge_pos_reg <= {POS_W{1'b0}};
         dist_reg <= {POS_W{1'b0}};
         shift_reg <= {POS_W{1'b0}};
         marker_flag_reg <= 1'b0;
         referenced_reg <= 1'b0;
         abs_ok_reg <= 1'b0;
         speed_cmd_reg <= 32'h00000000;
         motor_dir_neg_reg <= 1'b0;
         motor_run_reg <= 1'b0;
      end else begin
         mfb_reg <= hss_step(mfb_reg, motor_step, motor_step_up);
         dfb_reg <= hss_step(dfb_reg, direct_step, direct_step_up);
         if (wr_fire && awaddr_reg == `HSS_SHIFT_OFF) begin
            shift_reg <= hss_merge(shift_reg, wdata_reg, wstrb_reg);
         end
         if (cal_cmd) begin
            shift_reg <= dist_reg;
         end
         case (state_reg)
            ST_IDLE: begin
               motor_run_reg <= 1'b0;
               speed_cmd_reg <= 32'h00000000;
               // where the axis stands is checked by the switch state only: pressed goes to ST_LEAVE, released to ST_FAST
               if (home_cmd) begin
                  marker_flag_reg <= 1'b0;
                  referenced_reg <= 1'b0;
                  abs_ok_reg <= 1'b0;
                  motor_run_reg <= 1'b1;
                  if (sw_active) begin
                     state_reg <= ST_LEAVE;
                     motor_dir_neg_reg <= ~cfg_reg[`HSS_CFG_DIR];
                     speed_cmd_reg <= fast_reg;
                  end else begin
                     state_reg <= ST_FAST;
                     motor_dir_neg_reg <= cfg_reg[`HSS_CFG_DIR];
                     speed_cmd_reg <= fast_reg;
                  end
               end
            end
            ST_FAST: begin
               if (sw_active) begin
                  state_reg <= ST_LEAVE;
                  motor_dir_neg_reg <= ~cfg_reg[`HSS_CFG_DIR];
                  speed_cmd_reg <= fast_reg;
               end
            end
            ST_LEAVE: begin
               // released edge marks the switch position for the distance report
               if (!sw_active) begin
                  edge_pos_reg <= fb_sel;
                  state_reg <= ST_SLOW;
                  speed_cmd_reg <= slow_reg;
               end
            end
            ST_SLOW: begin
               if (marker_rise) begin
                  mark_reg <= fb_sel;
                  marker_flag_reg <= 1'b1;
                  motor_run_reg <= 1'b0;
                  speed_cmd_reg <= 32'h00000000;
                  dist_reg <= fb_sel - sw_eff_edge;
                  state_reg <= ST_CALC;
               end
            end
            ST_CALC: begin
               if (use_direct) begin
                  ddisp_reg <= dref_dist_reg - dref_ofs_reg - mark_reg;
               end else begin
                  mdisp_reg <= mref_dist_reg - mref_ofs_reg - mark_reg;
               end
               state_reg <= ST_SETFB;
            end
            ST_SETFB: begin
               // counts since the marker are kept so the new origin is exact
               if (use_direct) begin
                  dfb_reg <= hss_step(ddisp_reg + (dfb_reg - mark_reg),
                     direct_step, direct_step_up);
               end else begin
                  mfb_reg <= hss_step(mdisp_reg + (mfb_reg - mark_reg),
                     motor_step, motor_step_up);
               end
               state_reg <= ST_DONE;
            end
            ST_DONE: begin
               referenced_reg <= 1'b1;
               cmd_pos_reg <= fb_sel;
               abs_ok_reg <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // axi read; unaligned addresses and addresses past 0x44 answer slverr, ctrl reads 0 with okay
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `HSS_RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= hss_mapped(s_axi_araddr) ? `HSS_RESP_OKAY : `HSS_RESP_SLVERR;
         case (s_axi_araddr)
            `HSS_STAT_OFF: s_axi_rdata <= {27'h0000000, abs_ok_reg, sw_raw,
               referenced_reg, marker_flag_reg, state_reg != ST_IDLE};
            `HSS_CFG_OFF: s_axi_rdata <= cfg_reg;
            `HSS_FAST_OFF: s_axi_rdata <= fast_reg;
            `HSS_SLOW_OFF: s_axi_rdata <= slow_reg;
            `HSS_MREFDIST_OFF: s_axi_rdata <= mref_dist_reg;
            `HSS_MREFOFS_OFF: s_axi_rdata <= mref_ofs_reg;
            `HSS_DREFDIST_OFF: s_axi_rdata <= dref_dist_reg;
            `HSS_DREFOFS_OFF: s_axi_rdata <= dref_ofs_reg;
            `HSS_SHIFT_OFF: s_axi_rdata <= shift_reg;
            `HSS_MFB_OFF: s_axi_rdata <= mfb_reg;
            `HSS_DFB_OFF: s_axi_rdata <= dfb_reg;
            `HSS_MARK_OFF: s_axi_rdata <= mark_reg;
            `HSS_MDISP_OFF: s_axi_rdata <= mdisp_reg;
            `HSS_DDISP_OFF: s_axi_rdata <= ddisp_reg;
            `HSS_CMDPOS_OFF: s_axi_rdata <= cmd_pos_reg;
            `HSS_DIST_OFF: s_axi_rdata <= dist_reg;
            `HSS_SWSTAT_OFF: s_axi_rdata <= {31'h00000000, sw_raw};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // hss_sequencer
`default_nettype wire

// *** include/hss_regs.vh ***
// register offsets, field positions and reset values of the home search sequencer
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef HSS_REGS_VH
`define HSS_REGS_VH
`define HSS_CTRL_OFF 8'h00
`define HSS_STAT_OFF 8'h04
`define HSS_CFG_OFF 8'h08
`define HSS_FAST_OFF 8'h0c
`define HSS_SLOW_OFF 8'h10
`define HSS_MREFDIST_OFF 8'h14
`define HSS_MREFOFS_OFF 8'h18
`define HSS_DREFDIST_OFF 8'h1c
`define HSS_DREFOFS_OFF 8'h20
`define HSS_SHIFT_OFF 8'h24
`define HSS_MFB_OFF 8'h28
`define HSS_DFB_OFF 8'h2c
`define HSS_MARK_OFF 8'h30
`define HSS_MDISP_OFF 8'h34
`define HSS_DDISP_OFF 8'h38
`define HSS_CMDPOS_OFF 8'h3c
`define HSS_DIST_OFF 8'h40
`define HSS_SWSTAT_OFF 8'h44
`define HSS_CTRL_HOME 0
`define HSS_CTRL_CAL 1
`define HSS_CTRL_SRC 2
`define HSS_CFG_DIR 0
`define HSS_CFG_POL 1
`define HSS_CFG_DIRECT 2
`define HSS_CFG_PLC 3
`define HSS_ST_BUSY 0
`define HSS_ST_MARK 1
`define HSS_ST_REF 2
`define HSS_ST_SW 3
`define HSS_ST_ABS 4
`define HSS_FAST_RST 32'h00000400
`define HSS_SLOW_RST 32'h00000040
`define HSS_RESP_OKAY 2'b00
`define HSS_RESP_SLVERR 2'b10
`endif

// *** testbench/hss_chk.sv ***
// checker on the ports of the home search sequencer
// assumes one clock domain and untouched reset values of the speed registers
`timescale 1ns/1ps
`default_nettype none
`include "hss_regs.vh"
module hss_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic encoder_marker_pulse,
   input wire logic [31:0] speed_cmd_reg,
   input wire logic motor_run_reg
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken");
   a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("second write taken");
   a_stopped_speed: assert property (!motor_run_reg |-> speed_cmd_reg == 32'h0)
      else $error("speed while stopped");
   a_marker_stops: assert property ($rose(encoder_marker_pulse) && motor_run_reg
      && speed_cmd_reg == `HSS_SLOW_RST |-> ##[1:6] !motor_run_reg)
      else $error("no stop after marker");
   a_stop_at_slow: assert property ($fell(motor_run_reg)
      |-> $past(speed_cmd_reg) == `HSS_SLOW_RST) else $error("stop not at slow speed");
endmodule // hss_chk
bind hss_sequencer hss_chk hss_chk_i (.*);
`default_nettype wire

// *** testbench/hss_axis_model.sv ***
// far side model: motor, encoder and home switch on a line of counts
// assumes a speed above 0x100 means fast; a marker every 16 counts
`timescale 1ns/1ps
`default_nettype none
module hss_axis_model #(
   parameter int SW_POS = 40,
   parameter int FAST_PER = 6,
   parameter int SLOW_PER = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] speed_cmd,
   input wire logic dir_neg,
   input wire logic run,
   output logic home_switch_pin,
   output logic encoder_marker_pulse,
   output logic step,
   output logic step_up
);
   logic signed [31:0] pos = 32'sh0;
   int cnt = 0;
   int per;
   // slow steps keep the marker high well past the three-cycle detect delay
   assign per = (speed_cmd > 32'h100) ? FAST_PER : SLOW_PER;
   initial begin
      step = 1'b0;
      step_up = 1'b1;
   end
   always @(posedge aclk) begin
      step <= 1'b0;
      if (!aresetn) begin
         pos <= 32'sh0;
         cnt <= 0;
      end else if (run) begin
         if (cnt >= per - 1) begin
            cnt <= 0;
            pos <= dir_neg ? pos - 1 : pos + 1;
            step <= 1'b1;
            step_up <= !dir_neg;
         end else begin
            cnt <= cnt + 1;
         end
      end else begin
         cnt <= 0;
      end
   end
   // raw contact closes at SW_POS and beyond; polarity is left to the device
   assign home_switch_pin = (pos >= SW_POS);
   assign encoder_marker_pulse = (pos[3:0] == 4'h5);
endmodule // hss_axis_model
`default_nettype wire

// *** testbench/hss_sequencer_tb.sv ***
// self-checking bench for the home search sequencer over axi4-lite
// assumes the axis model on the far side and a 25 MHz aclk
`timescale 1ns/1ps
`default_nettype none
`include "hss_regs.vh"
module hss_sequencer_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, speed_cmd_reg;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire motor_dir_neg_reg, motor_run_reg, home_switch_pin, encoder_marker_pulse;
   wire motor_step, motor_step_up;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] rv;
   logic [1:0] rr;
   always #20 aclk = ~aclk;
   // direct feedback rides on the same counts so both sets see one axis
   hss_sequencer hss_sequencer_i (.*, .direct_step(motor_step), .direct_step_up(motor_step_up));
   hss_axis_model hss_axis_model_i (.aclk(aclk), .aresetn(aresetn), .speed_cmd(speed_cmd_reg),
      .dir_neg(motor_dir_neg_reg), .run(motor_run_reg), .home_switch_pin(home_switch_pin),
      .encoder_marker_pulse(encoder_marker_pulse), .step(motor_step), .step_up(motor_step_up));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta = 1'b0;
      logic tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta |= s_axi_awready;
         tw |= s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rv, exp);
   endtask
   // polling waits on the referenced flag, which a fresh home command clears
   task automatic home;
      wr(`HSS_CTRL_OFF, 32'h1);
      do rd(`HSS_STAT_OFF); while (rv[`HSS_ST_REF] !== 1'b1);
   endtask
   task automatic rst;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         $display("wrong value at %0t ns: run did not finish", $time);
         wrap_up();
      end
   end
   initial begin
      rst();
      rc(`HSS_FAST_OFF, `HSS_FAST_RST);
      rc(`HSS_SLOW_OFF, `HSS_SLOW_RST);
      rc(`HSS_MFB_OFF, 32'h0);
      rc(`HSS_STAT_OFF, 32'h0);
      rd(8'h48);
      chk({30'h0, rr}, {30'h0, `HSS_RESP_SLVERR});
      wr(8'h48, 32'h1);
      chk({30'h0, rr}, {30'h0, `HSS_RESP_SLVERR});
      // released at start: fast approach, back off, slow marker search
      wr(`HSS_MREFDIST_OFF, 32'h3e8);
      wr(`HSS_MREFOFS_OFF, 32'h64);
      home();
      rc(`HSS_MARK_OFF, 32'h25);
      rc(`HSS_STAT_OFF, 32'h16);
      rc(`HSS_MDISP_OFF, 32'h35f);
      rc(`HSS_MFB_OFF, 32'h35f);
      rc(`HSS_CMDPOS_OFF, 32'h35f);
      rc(`HSS_DIST_OFF, 32'hfffffffe);
      wr(`HSS_CTRL_OFF, 32'h2);
      rc(`HSS_SHIFT_OFF, 32'hfffffffe);
      // pressed at start through inverted polarity, reversed direction
      rst();
      wr(`HSS_CFG_OFF, 32'h3);
      home();
      rc(`HSS_MARK_OFF, 32'h35);
      rc(`HSS_MFB_OFF, 32'hffffffcb);
      rc(`HSS_DIST_OFF, 32'hd);
      // second parameter set with direct feedback
      rst();
      wr(`HSS_CFG_OFF, 32'h4);
      wr(`HSS_DREFDIST_OFF, 32'h1f4);
      wr(`HSS_DREFOFS_OFF, 32'h14);
      home();
      rc(`HSS_DDISP_OFF, 32'h1bb);
      rc(`HSS_DFB_OFF, 32'h1bb);
      rc(`HSS_CMDPOS_OFF, 32'h1bb);
      // switch state handed over by the controller, then back to the pin
      wr(`HSS_CFG_OFF, 32'h8);
      wr(`HSS_SWSTAT_OFF, 32'h1);
      rd(`HSS_STAT_OFF);
      chk({31'h0, rv[`HSS_ST_SW]}, 32'h1);
      wr(`HSS_CFG_OFF, 32'h0);
      rd(`HSS_STAT_OFF);
      chk({31'h0, rv[`HSS_ST_SW]}, 32'h0);
      wrap_up();
   end
endmodule // hss_sequencer_tb
`default_nettype wire
